/* File: dual_comm_watchdog.sv */
// Bus-side and application-side communication watchdogs with a shared prescaler.
`timescale 1ns/1ps

// Operation
// - Both watchdogs take their tick from the 25 MHz base by dividing it by multiplier plus two.
// - One watchdog tick spans multiplier plus two base periods of 40 ns.
// - The default multiplier of 2498 yields a watchdog tick of 100 us.
// - A single multiplier feeds the one prescaler that both watchdogs share.
// - Each watchdog keeps its own timeout count, and its period is that count times the tick.
// - A bus-side count of 10000 with a 100 us tick supervises for one second.
// - The bus-side count defaults to 1000, giving 100 ms with the default tick.
// - The bus-side count accepts 0 to 65535 and the multiplier accepts 1 to 65535.
// - The bus-side watchdog restarts on each successful process-data access and on each configuration load.
// - On bus-side expiry all process-data outputs (out_data_o) are driven to logic false.
// - Bus-side expiry leaves the operational state of the slave state machine untouched.
// - The application-side watchdog trips when no local interface access comes within its timeout.
// - A bus-side count of zero disables that watchdog so outputs are never forced off.
module dual_comm_watchdog #(
   parameter int DATA_W = 8
) (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   // Configuration download
   input  wire logic              cfg_load_i,
   input  wire logic [15:0]       multiplier_i,
   input  wire logic [15:0]       bus_timeout_i,
   input  wire logic [15:0]       app_timeout_i,
   // Communication events
   input  wire logic              bus_pd_access_i,
   input  wire logic              app_access_i,
   // Process outputs and state
   input  wire logic [DATA_W-1:0] out_data_i,
   input  wire logic [3:0]        operational_state_i,
   output logic      [DATA_W-1:0] out_data_o,
   output logic      [3:0]        operational_state_o,
   // Status
   output logic                   wd_tick_o,
   output logic                   bus_expired_o,
   output logic                   app_expired_o
);

   // ****************************************
   // State
   // ****************************************
   logic [1:0]        base_cnt;
   logic [1:0]        next_base_cnt;
   logic              base_tick;
   logic              next_base_tick;
   logic [16:0]       pre_cnt;
   logic [16:0]       next_pre_cnt;
   logic              next_wd_tick;
   logic [15:0]       mult;
   logic [15:0]       next_mult;
   logic [15:0]       timeout     [dual_comm_watchdog_pkg::NUM_WD];
   logic [15:0]       next_timeout[dual_comm_watchdog_pkg::NUM_WD];
   logic [15:0]       wd_cnt      [dual_comm_watchdog_pkg::NUM_WD];
   logic [15:0]       next_wd_cnt [dual_comm_watchdog_pkg::NUM_WD];
   logic              expired     [dual_comm_watchdog_pkg::NUM_WD];
   logic              next_expired[dual_comm_watchdog_pkg::NUM_WD];
   logic              access      [dual_comm_watchdog_pkg::NUM_WD];
   logic [15:0]       load_to     [dual_comm_watchdog_pkg::NUM_WD];
   logic [DATA_W-1:0] next_out_data;
   logic [16:0]       pre_last;

   assign access[dual_comm_watchdog_pkg::WD_BUS]  = bus_pd_access_i;
   assign access[dual_comm_watchdog_pkg::WD_APP]  = app_access_i;
   assign load_to[dual_comm_watchdog_pkg::WD_BUS] = bus_timeout_i;
   assign load_to[dual_comm_watchdog_pkg::WD_APP] = app_timeout_i;

   // ****************************************
   // Base tick and shared prescaler
   // ****************************************
   always_comb begin
      next_base_tick = (base_cnt == dual_comm_watchdog_pkg::BASE_DIV_LAST);
      next_base_cnt  = next_base_tick ? 2'h0 : 2'(base_cnt + 2'h1);
      pre_last       = 17'({1'b0, mult} + dual_comm_watchdog_pkg::MULT_OFFSET - 17'h00001);
      next_pre_cnt   = pre_cnt;
      next_wd_tick   = 1'b0;
      if (base_tick) begin
         if (pre_cnt >= pre_last) begin
            next_pre_cnt = 17'h00000;
            next_wd_tick = 1'b1;
         end else begin
            next_pre_cnt = 17'(pre_cnt + 17'h00001);
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         base_cnt  <= 2'h0;
         base_tick <= 1'b0;
         pre_cnt   <= 17'h00000;
         wd_tick_o <= 1'b0;
      end else begin
         base_cnt  <= next_base_cnt;
         base_tick <= next_base_tick;
         pre_cnt   <= next_pre_cnt;
         wd_tick_o <= next_wd_tick;
      end
   end

   // ****************************************
   // Configuration
   // ****************************************
   always_comb begin
      next_mult = mult;
      for (int i = 0; i < dual_comm_watchdog_pkg::NUM_WD; i++) begin
         next_timeout[i] = timeout[i];
      end
      if (cfg_load_i) begin
         next_mult = (multiplier_i < dual_comm_watchdog_pkg::MULT_MIN) ?
                     dual_comm_watchdog_pkg::MULT_MIN : multiplier_i;
         for (int i = 0; i < dual_comm_watchdog_pkg::NUM_WD; i++) begin
            next_timeout[i] = load_to[i];
         end
      end
   end

   // ****************************************
   // Watchdog counters
   // ****************************************
   always_comb begin
      for (int i = 0; i < dual_comm_watchdog_pkg::NUM_WD; i++) begin
         next_wd_cnt[i]  = wd_cnt[i];
         next_expired[i] = expired[i];
         if (next_timeout[i] == dual_comm_watchdog_pkg::TO_DISABLED) begin
            next_wd_cnt[i]  = 16'h0000;
            next_expired[i] = 1'b0;
         end else if (access[i] || cfg_load_i) begin
            next_wd_cnt[i]  = next_timeout[i];
            next_expired[i] = 1'b0;
         end else if (wd_tick_o && (wd_cnt[i] != 16'h0000)) begin
            next_wd_cnt[i] = 16'(wd_cnt[i] - 16'h0001);
            if (wd_cnt[i] == 16'h0001) begin
               next_expired[i] = 1'b1;
            end
         end
      end
      next_out_data = next_expired[dual_comm_watchdog_pkg::WD_BUS] ? '0 : out_data_i;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mult                                    <= dual_comm_watchdog_pkg::MULT_RESET;
         timeout[dual_comm_watchdog_pkg::WD_BUS] <= dual_comm_watchdog_pkg::BUS_TO_RESET;
         timeout[dual_comm_watchdog_pkg::WD_APP] <= dual_comm_watchdog_pkg::APP_TO_RESET;
         wd_cnt[dual_comm_watchdog_pkg::WD_BUS]  <= dual_comm_watchdog_pkg::BUS_TO_RESET;
         wd_cnt[dual_comm_watchdog_pkg::WD_APP]  <= dual_comm_watchdog_pkg::APP_TO_RESET;
         expired[dual_comm_watchdog_pkg::WD_BUS] <= 1'b0;
         expired[dual_comm_watchdog_pkg::WD_APP] <= 1'b0;
         out_data_o                              <= '0;
         operational_state_o                     <= 4'h0;
         bus_expired_o                           <= 1'b0;
         app_expired_o                           <= 1'b0;
      end else begin
         mult <= next_mult;
         for (int i = 0; i < dual_comm_watchdog_pkg::NUM_WD; i++) begin
            timeout[i] <= next_timeout[i];
            wd_cnt[i]  <= next_wd_cnt[i];
            expired[i] <= next_expired[i];
         end
         out_data_o          <= next_out_data;
         operational_state_o <= operational_state_i;
         bus_expired_o       <= next_expired[dual_comm_watchdog_pkg::WD_BUS];
         app_expired_o       <= next_expired[dual_comm_watchdog_pkg::WD_APP];
      end
   end

endmodule

/* File: dual_comm_watchdog_monitor.sv */
// Port checker for the dual communication watchdog.
`timescale 1ns/1ps
module dual_comm_watchdog_monitor #(
   parameter int DATA_W = 8
) (
   input wire logic              clk_i,
   input wire logic              rst_n_i,
   input wire logic              cfg_load_i,
   input wire logic              bus_pd_access_i,
   input wire logic              app_access_i,
   input wire logic [DATA_W-1:0] out_data_i,
   input wire logic [3:0]        operational_state_i,
   input wire logic [DATA_W-1:0] out_data_o,
   input wire logic [3:0]        operational_state_o,
   input wire logic              wd_tick_o,
   input wire logic              bus_expired_o,
   input wire logic              app_expired_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   AST_TICK_GAP: assert property (wd_tick_o |=> !wd_tick_o [*8])
      else $error("tick pulses too close");
   AST_OUT_OFF: assert property (bus_expired_o |-> out_data_o == '0)
      else $error("outputs live while expired");
   AST_OUT_PASS: assert property ($past(rst_n_i) && !bus_expired_o |-> out_data_o == $past(out_data_i))
      else $error("outputs not passed through");
   AST_STATE: assert property ($past(rst_n_i) |-> operational_state_o == $past(operational_state_i))
      else $error("state disturbed");
   AST_BUS_RESTART: assert property (bus_pd_access_i |=> !bus_expired_o)
      else $error("bus access did not restart");
   AST_APP_RESTART: assert property (app_access_i |=> !app_expired_o)
      else $error("local access did not restart");
   AST_BUS_RISE: assert property ($rose(bus_expired_o) |-> $past(wd_tick_o) && !$past(bus_pd_access_i))
      else $error("bus expiry off tick");
   AST_CFG_CLEAR: assert property (cfg_load_i |=> !bus_expired_o && !app_expired_o)
      else $error("load did not clear expiry");
   cover property ($rose(bus_expired_o));
   cover property ($rose(app_expired_o));
   cover property (bus_pd_access_i && bus_expired_o);
endmodule

/* File: dual_comm_watchdog_pkg.sv */
// Constants shared by the dual communication watchdog.
package dual_comm_watchdog_pkg;

   // ****************************************
   // Clock and base tick
   // ****************************************
   localparam int          CLK_FREQ_MHZ   = 100;
   localparam int          BASE_FREQ_MHZ  = 25;
   localparam int          BASE_PERIOD_NS = 40;
   localparam int          BASE_DIV       = CLK_FREQ_MHZ / BASE_FREQ_MHZ;
   localparam logic [1:0]  BASE_DIV_LAST  = 2'(BASE_DIV - 1);

   // ****************************************
   // Configuration fields
   // ****************************************
   localparam int          CFG_W          = 16;
   localparam int          NUM_WD         = 2;
   localparam int          WD_BUS         = 0;
   localparam int          WD_APP         = 1;
   localparam logic [15:0] MULT_RESET     = 16'h09c2;
   localparam logic [15:0] MULT_MIN       = 16'h0001;
   localparam logic [16:0] MULT_OFFSET    = 17'h00002;
   localparam logic [15:0] BUS_TO_RESET   = 16'h03e8;
   localparam logic [15:0] APP_TO_RESET   = 16'h03e8;
   localparam logic [15:0] TO_DISABLED    = 16'h0000;

endpackage

/* File: dual_comm_watchdog_test.sv */
// Self-checking bench for the dual communication watchdog.
`timescale 1ns/1ps
module dual_comm_watchdog_test;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        cfg = 1'b0;
   logic        bus_run = 1'b0;
   logic        app_run = 1'b0;
   logic [15:0] mult = 16'h09c2;
   logic [15:0] bto = 16'h03e8;
   logic [15:0] ato = 16'h03e8;
   logic [7:0]  dat_i = 8'ha5;
   logic [3:0]  st_i = 4'h8;
   logic [7:0]  dat_o;
   logic [3:0]  st_o;
   logic        tick, bexp, aexp, bacc, aacc;
   int          fails = 0;
   int          samples_checked = 0;
   int          n;
   dual_comm_watchdog i_dut (.clk_i, .rst_n_i, .cfg_load_i(cfg), .multiplier_i(mult), .bus_timeout_i(bto),
      .app_timeout_i(ato), .bus_pd_access_i(bacc), .app_access_i(aacc), .out_data_i(dat_i),
      .operational_state_i(st_i), .out_data_o(dat_o), .operational_state_o(st_o), .wd_tick_o(tick),
      .bus_expired_o(bexp), .app_expired_o(aexp));
   wd_partner_model i_far (.clk_i, .bus_run_i(bus_run), .app_run_i(app_run), .gap_i(8'h08),
      .bus_acc_o(bacc), .app_acc_o(aacc));
   initial forever #5 clk_i = ~clk_i;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic load(input logic [15:0] m, input logic [15:0] b, input logic [15:0] a);
      {mult, bto, ato, cfg} = {m, b, a, 1'b1};
      @(negedge clk_i) cfg = 1'b0;
   endtask
   // Measures clocks from one tick to the next.
   task automatic gap(output int g);
      for (g = 0; g < 20000 && tick !== 1'b1; g++) @(negedge clk_i);
      g = 0;
      do begin
         @(negedge clk_i);
         g++;
      end while (tick !== 1'b1 && g < 20000);
   endtask
   task automatic end_sim;
      $display("fails=%0d samples_checked=%0d", fails, samples_checked);
      if (fails == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #500000;
      fails++;
      end_sim;
   end
   initial begin
      repeat (20) @(negedge clk_i);
      rst_n_i = 1'b1;
      @(negedge clk_i);
      chk({15'h0000, bexp | aexp}, 16'h0000);
      chk({8'h00, dat_o}, 16'h00a5);
      gap(n);
      chk(16'(n), 16'h2710);
      $display("test defaults done");
      load(16'h0001, 16'h0003, 16'h0000);
      gap(n);
      chk(16'(n), 16'h000c);
      load(16'h0001, 16'h0003, 16'h0000);
      repeat (22) @(negedge clk_i);
      chk({15'h0000, bexp}, 16'h0000);
      repeat (18) @(negedge clk_i);
      chk({15'h0000, bexp}, 16'h0001);
      chk({8'h00, dat_o}, 16'h0000);
      chk({12'h000, st_o}, 16'h0008);
      bus_run = 1'b1;
      repeat (200) @(negedge clk_i);
      chk({7'h00, bexp, dat_o}, 16'h00a5);
      bus_run = 1'b0;
      $display("test bus expiry done");
      load(16'h0001, 16'h0000, 16'h0002);
      repeat (40) @(negedge clk_i);
      chk({15'h0000, aexp}, 16'h0001);
      chk({7'h00, bexp, dat_o}, 16'h00a5);
      app_run = 1'b1;
      repeat (100) @(negedge clk_i);
      chk({15'h0000, aexp}, 16'h0000);
      $display("test disable and local done");
      load(16'h0000, 16'h0000, 16'h0000);
      gap(n);
      chk(16'(n), 16'h000c);
      load(16'h0005, 16'h0000, 16'h0000);
      gap(n);
      chk(16'(n), 16'h001c);
      $display("test multiplier done");
      dat_i = 8'h3c;
      st_i = 4'h2;
      repeat (2) @(negedge clk_i);
      chk({8'h00, dat_o}, 16'h003c);
      chk({12'h000, st_o}, 16'h0002);
      rst_n_i = 1'b0;
      @(negedge clk_i);
      chk({8'h00, dat_o}, 16'h0000);
      rst_n_i = 1'b1;
      repeat (2) @(negedge clk_i);
      chk({14'h0000, bexp, aexp}, 16'h0000);
      chk({12'h000, st_o}, 16'h0002);
      $display("test pass-through and reset done");
      end_sim;
   end
endmodule
bind dual_comm_watchdog dual_comm_watchdog_monitor #(.DATA_W(DATA_W)) i_mon (.clk_i, .rst_n_i, .cfg_load_i,
   .bus_pd_access_i, .app_access_i, .out_data_i, .operational_state_i, .out_data_o, .operational_state_o,
   .wd_tick_o, .bus_expired_o, .app_expired_o);

/* File: wd_partner_model.sv */
// Bus master and local processor issuing periodic accesses.
`timescale 1ns/1ps
module wd_partner_model (
   input  wire logic       clk_i,
   input  wire logic       bus_run_i,
   input  wire logic       app_run_i,
   input  wire logic [7:0] gap_i,
   output logic            bus_acc_o = 1'b0,
   output logic            app_acc_o = 1'b0
);
   logic [7:0] cnt = 8'h00;
   // Accesses come as one-cycle pulses every gap plus one cycles.
   always @(negedge clk_i) begin
      cnt <= (cnt == gap_i) ? 8'h00 : cnt + 8'h01;
      bus_acc_o <= bus_run_i && cnt == gap_i;
      app_acc_o <= app_run_i && cnt == gap_i;
   end
endmodule
